// ---- dv/caf_engine_model.sv ----
// protocol engine stand-in: frames, error counts and mode acknowledges
`timescale 1ns/10ps
`default_nettype none

module caf_engine_model (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // commands from the bench
  input  wire logic                sendReq,
  input  wire caf_pkg::caf_frame_s sendFrame,
  input  wire logic [7:0]          rxCountSet,
  input  wire logic [7:0]          txCountSet,
  // mode requests from the filter
  input  wire logic                initRequest,
  input  wire logic                sleepRequest,
  // toward the filter
  output var caf_pkg::caf_frame_s  frameIn,
  output var logic                 frameValid,
  output wire logic [7:0]          rxErrorCount,
  output wire logic [7:0]          txErrorCount,
  output var logic                 initAcknowledge,
  output var logic                 sleepAcknowledge
);
  // ----------------------------------------------------------------
  // frame delivery and acknowledges
  // ----------------------------------------------------------------
  // one-cycle frame pulse; between frames the lines show the inverse
  // of the last value so a stale identifier is never mistaken for data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frameValid       <= 1'b0;
      frameIn          <= '0;
      initAcknowledge  <= 1'b0;
      sleepAcknowledge <= 1'b0;
    end else begin
      frameValid       <= sendReq;
      frameIn          <= sendReq ? sendFrame : ~frameIn;
      // acknowledges trail the requests by one cycle, like a slow engine
      initAcknowledge  <= initRequest;
      sleepAcknowledge <= sleepRequest;
    end
  end

  // live counters as the engine would hold them
  assign rxErrorCount = rxCountSet;
  assign txErrorCount = txCountSet;
endmodule

`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the acceptance filter
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ----------------------------------------------------------------
  // signals and tables
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          mode;  // filter organisation
    caf_pkg::caf_frame_s fr;    // frame sent
    logic                acc;   // frame should be accepted
    logic [2:0]          hit;   // expected hit index
  } caf_row_s;
  logic                clk = 1'b0, rstN = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic                sendReq = 1'b0, ack, frameValid, initAck, slpAck;
  logic                initReq, slpReq, rxFull, frameAcc;
  logic [7:0]          adr = 8'h00, rxCnt, txCnt;
  logic [3:0]          sel = 4'h0;
  logic [31:0]         datI = 32'h0, datO;
  logic [2:0]          hitIdx, hit = 3'h0;
  caf_pkg::caf_frame_s frameIn, fgFrame, sendFrame = '0;
  int                  errCount = 0, testsRun = 0, accCount = 0, n0;
  logic [7:0]          codeV [8] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'hDE, 8'hF0};
  logic [7:0]          maskV [8] = '{8'h00, 8'h07, 8'h00, 8'h07, 8'h00, 8'h07, 8'h0F, 8'hFF};
  caf_row_s            rows [12] = '{
    '{2'h0, {1'b1, 32'h12345678}, 1'b1, 3'h0}, '{2'h0, {1'b1, 32'h12355678}, 1'b1, 3'h0},
    '{2'h0, {1'b1, 32'h123C5678}, 1'b0, 3'h0}, '{2'h0, {1'b1, 32'h9ABCD500}, 1'b1, 3'h1},
    '{2'h0, {1'b0, 32'h1234FFFF}, 1'b1, 3'h0}, '{2'h0, {1'b1, 32'h1234FFFF}, 1'b0, 3'h0},
    '{2'h1, {1'b1, 32'h56780000}, 1'b1, 3'h1}, '{2'h1, {1'b0, 32'hD3000000}, 1'b1, 3'h3},
    '{2'h2, {1'b1, 32'hD0000000}, 1'b1, 3'h6}, '{2'h2, {1'b0, 32'h56000000}, 1'b1, 3'h2},
    '{2'h2, {1'b1, 32'h00000000}, 1'b1, 3'h7}, '{2'h3, {1'b1, 32'h12345678}, 1'b0, 3'h0}};

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // count acceptance pulses
  always @(posedge clk) begin
    if (frameAcc === 1'b1) accCount <= accCount + 1;
  end

  // ----------------------------------------------------------------
  // design and engine model
  // ----------------------------------------------------------------
  caf_acceptance_filter dut_u (.clk(clk), .rst_n(rstN), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack),
    .frameIn(frameIn), .frameValid(frameValid), .rxErrorCount(rxCnt),
    .txErrorCount(txCnt), .initAcknowledge(initAck), .sleepAcknowledge(slpAck),
    .initRequest(initReq), .sleepRequest(slpReq), .rxBufferFull(rxFull),
    .frameAccepted(frameAcc), .fgFrame(fgFrame), .filterHitIndex(hitIdx));
  caf_engine_model eng_u (.clk(clk), .rst_n(rstN), .sendReq(sendReq),
    .sendFrame(sendFrame), .rxCountSet(8'h5A), .txCountSet(8'hA3),
    .initRequest(initReq), .sleepRequest(slpReq), .frameIn(frameIn),
    .frameValid(frameValid), .rxErrorCount(rxCnt), .txErrorCount(txCnt),
    .initAcknowledge(initAck), .sleepAcknowledge(slpAck));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic endSim;
    if (errCount == 0 && testsRun > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    testsRun++;
    if (g !== e) begin
      errCount++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [5:0] i, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    datI <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk(1'b0, 1'b1);
  endtask

  task automatic wr(input logic [5:0] i, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, i, d, q);
  endtask

  task automatic rd(input logic [5:0] i, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, i, 32'h0, q);
    chk(33'(q), 33'(e));
  endtask

  // one frame through the engine, then time for the filter to settle
  task automatic send(input caf_pkg::caf_frame_s f);
    @(posedge clk);
    sendReq <= 1'b1;
    sendFrame <= f;
    @(posedge clk);
    sendReq <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // word index of code or mask slot s
  function automatic logic [5:0] slot(input logic m, input int s);
    if (s < 4) return (m ? caf_pkg::IDX_MASK_BANK0 : caf_pkg::IDX_CODE_BANK0) + 6'(s);
    return (m ? caf_pkg::IDX_MASK_BANK1 : caf_pkg::IDX_CODE_BANK1) + 6'(s - 4);
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rstN <= 1'b1;
    chk(33'(initReq), 33'h1);
    for (int b = 0; b < 4; b++) rd(caf_pkg::IDX_MASK_BANK1 + 6'(b), 32'h0);
    // program every slot while init is acknowledged
    for (int s = 0; s < 8; s++) begin
      wr(slot(1'b0, s), 32'(codeV[s]));
      wr(slot(1'b1, s), 32'(maskV[s]));
      rd(slot(1'b0, s), 32'(codeV[s]));
      rd(slot(1'b1, s), 32'(maskV[s]));
    end
    // error counters in init, in sleep, and in normal mode
    rd(caf_pkg::IDX_RX_ERR_COUNT, 32'h5A);
    rd(caf_pkg::IDX_TX_ERR_COUNT, 32'hA3);
    wr(caf_pkg::IDX_RX_ERR_COUNT, 32'hFF);
    rd(caf_pkg::IDX_RX_ERR_COUNT, 32'h5A);
    wr(caf_pkg::IDX_MODE_CTRL, 32'h2);
    chk(33'(slpReq), 33'h1);
    rd(caf_pkg::IDX_TX_ERR_COUNT, 32'hA3);
    wr(caf_pkg::IDX_CODE_BANK0, 32'h77);
    rd(caf_pkg::IDX_CODE_BANK0, 32'h12);
    wr(caf_pkg::IDX_MODE_CTRL, 32'h0);
    rd(caf_pkg::IDX_RX_ERR_COUNT, 32'h0);
    rd(6'h3F, 32'h0);
    // table of frames across all filter organisations
    for (int r = 0; r < 12; r++) begin
      n0 = accCount;
      wr(caf_pkg::IDX_MODE_CTRL, 32'h1);
      wr(caf_pkg::IDX_FILTER_CTRL, 32'(rows[r].mode) << 4);
      wr(caf_pkg::IDX_MODE_CTRL, 32'h0);
      send(rows[r].fr);
      if (rows[r].acc) hit = rows[r].hit;
      chk(33'(accCount - n0), 33'(rows[r].acc));
      chk(33'(rxFull), 33'(rows[r].acc));
      if (rows[r].acc) chk(fgFrame, rows[r].fr);
      chk(33'(hitIdx), 33'(hit));
      rd(caf_pkg::IDX_FILTER_CTRL, {26'h0, rows[r].mode, 1'b0, hit});
      wr(caf_pkg::IDX_RX_STATUS, 32'h1);
    end
    // second accepted frame while the queue is still full is dropped
    wr(caf_pkg::IDX_MODE_CTRL, 32'h1);
    wr(caf_pkg::IDX_FILTER_CTRL, 32'h0);
    wr(caf_pkg::IDX_MODE_CTRL, 32'h0);
    n0 = accCount;
    send(rows[0].fr);
    send(rows[3].fr);
    chk(33'(accCount - n0), 33'h1);
    chk(fgFrame, rows[0].fr);
    wr(caf_pkg::IDX_RX_STATUS, 32'h1);
    rd(caf_pkg::IDX_RX_STATUS, 32'h8);
    send(rows[3].fr);
    chk(fgFrame, rows[3].fr);
    chk(33'(hitIdx), 33'h1);
    rd(caf_pkg::IDX_FG_ID, rows[3].fr.id);
    // a clear landing on the accepting edge loses to the set
    wr(caf_pkg::IDX_RX_STATUS, 32'h1);
    fork
      send(rows[3].fr);
      begin
        repeat (2) @(posedge clk);
        wr(caf_pkg::IDX_RX_STATUS, 32'h1);
      end
    join
    chk(33'(rxFull), 33'h1);
    // reset in mid-run clears the receive side
    @(posedge clk);
    rstN <= 1'b0;
    @(posedge clk);
    rstN <= 1'b1;
    chk(33'(rxFull), 33'h0);
    chk(fgFrame, 33'h0);
    rd(caf_pkg::IDX_FILTER_CTRL, 32'h0);
    endSim();
  end

  // watchdog at 10000 cycles, well beyond the expected run of a few hundred cycles
  initial begin
    #50000;
    errCount++;
    endSim();
  end
endmodule

`default_nettype wire

// ---- inc/caf_pkg.sv ----
// package: register map, field layout, reset values and carriers of the acceptance filter
package caf_pkg;

  // ----------------------------------------------------------------
  // register word indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_FILTER_CTRL     = 6'h0B;  // filter mode and hit index
  localparam logic [5:0] IDX_RX_ERR_COUNT    = 6'h0E;  // rx_error_count_reg, read only
  localparam logic [5:0] IDX_TX_ERR_COUNT    = 6'h0F;  // tx_error_count_reg, read only
  localparam logic [5:0] IDX_CODE_BANK0      = 6'h10;  // accept_code_bank0_byte0..3
  localparam logic [5:0] IDX_MASK_BANK0      = 6'h14;  // mask_bank0_byte0..3
  localparam logic [5:0] IDX_CODE_BANK1      = 6'h18;  // accept_code_bank1_byte0..3
  localparam logic [5:0] IDX_MASK_BANK1      = 6'h1C;  // mask_bank1_byte0..3 (0x1C..0x1F)
  localparam logic [5:0] IDX_MODE_CTRL       = 6'h20;  // init and sleep requests
  localparam logic [5:0] IDX_RX_STATUS       = 6'h21;  // full flag and acknowledges
  localparam logic [5:0] IDX_FG_ID           = 6'h22;  // identifier in foreground buffer

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FILTER_MODE_LSB   = 4;   // filter_mode_select [5:4]
  localparam int FILTER_HIT_LSB    = 0;   // filter_hit_index [2:0]
  localparam int MODE_INIT_BIT     = 0;   // init_request
  localparam int MODE_SLEEP_BIT    = 1;   // sleep_request
  localparam int STAT_FULL_BIT     = 0;   // rx_buffer_full_flag, write one clears
  localparam int STAT_INIT_ACK_BIT = 1;   // init_acknowledge as seen
  localparam int STAT_SLP_ACK_BIT  = 2;   // sleep_acknowledge as seen
  localparam int STAT_FG_EXT_BIT   = 3;   // foreground frame is extended

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_CODE        = 8'h00;
  localparam logic [7:0] RESET_MASK        = 8'h00;
  localparam logic [1:0] RESET_FILTER_MODE = 2'h0;
  localparam logic       RESET_INIT_REQ    = 1'b1;  // block starts in initialization mode

  // ----------------------------------------------------------------
  // filter organisations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CAF_FILTER_32   = 2'h0,  // two 32-bit filters
    CAF_FILTER_16   = 2'h1,  // four 16-bit filters
    CAF_FILTER_8    = 2'h2,  // eight 8-bit filters
    CAF_FILTER_SHUT = 2'h3   // filter closed
  } caf_filter_mode_e;

  // received frame from the protocol engine; id[31:24] is identifier byte 0
  typedef struct packed {
    logic        ext;  // extended format
    logic [31:0] id;   // frame_id_bytes 0..3
  } caf_frame_s;

endpackage

// ---- logic/caf_acceptance_filter.sv ----
// acceptance filter, error-counter read-out and classic wishbone register slave
`timescale 1ns/10ps
`default_nettype none

module caf_acceptance_filter (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // wishbone classic slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [7:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output wire logic [31:0]        dat_o,
  output wire logic               ack_o,
  // protocol engine side
  input  wire caf_pkg::caf_frame_s frameIn,
  input  wire logic               frameValid,
  input  wire logic [7:0]         rxErrorCount,
  input  wire logic [7:0]         txErrorCount,
  input  wire logic               initAcknowledge,
  input  wire logic               sleepAcknowledge,
  output wire logic               initRequest,
  output wire logic               sleepRequest,
  // receive queue side
  output wire logic               rxBufferFull,
  output wire logic               frameAccepted,
  output wire caf_pkg::caf_frame_s fgFrame,
  output wire logic [2:0]         filterHitIndex
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0][7:0] code;          // accept_code_bits, slot = bank*4 + byte
    logic [7:0][7:0] mask;          // accept_mask_bits, same slots
    logic [1:0]      filterMode;    // filter_mode_select
    logic [2:0]      hitIndex;      // filter_hit_index
    logic            initReq;       // init_request
    logic            sleepReq;      // sleep_request
    logic            rxFull;        // rx_buffer_full_flag
    caf_pkg::caf_frame_s bgFrame;   // background receive buffer
    logic            evalPending;   // background frame awaits filtering
    caf_pkg::caf_frame_s fgFrame;   // rx_foreground_buffer
    logic            acceptPulse;   // one-cycle accept event
    logic            ack;           // bus answer
    logic [31:0]     rdData;        // bus read data
  } caf_state_s;

  typedef struct packed {
    logic       hit;     // address is a code or mask byte
    logic       isMask;  // mask rather than code
    logic [2:0] slot;    // bank*4 + byte
  } caf_slot_s;

  caf_state_s stateReg;   // registered state
  caf_state_s stateNext;  // next state

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // decode a word index into a code or mask slot
  function automatic caf_slot_s decodeSlot(input logic [5:0] idx);
    caf_slot_s s;
    s.hit    = (idx[5:3] == caf_pkg::IDX_CODE_BANK0[5:3]) ||
               (idx[5:3] == caf_pkg::IDX_CODE_BANK1[5:3]);
    s.isMask = idx[2];
    s.slot   = {idx[3], idx[1:0]};
    return s;
  endfunction

  // one byte compare: per bit equality, then mask one forces a pass
  function automatic logic byteMatch(input logic [7:0] idByte,
                                     input logic [7:0] codeByte,
                                     input logic [7:0] maskByte);
    return &(~(idByte ^ codeByte) | maskByte);
  endfunction

  // identifier byte n of a frame
  function automatic logic [7:0] idByteOf(input logic [31:0] id, input int n);
    return id[31 - 8*n -: 8];
  endfunction

  // hit vector, one bit per filter number
  function automatic logic [7:0] filterHits(input logic [1:0]      fmode,
                                            input logic [7:0][7:0] code,
                                            input logic [7:0][7:0] mask,
                                            input caf_pkg::caf_frame_s fr);
    logic [7:0] hits;
    logic       ok;
    hits = 8'h00;
    ok   = 1'b0;
    unique case (caf_pkg::caf_filter_mode_e'(fmode))
      caf_pkg::CAF_FILTER_32: begin
        for (int f = 0; f < 2; f++) begin
          ok = 1'b1;
          for (int b = 0; b < 4; b++) begin
            // standard frames use only the first two bytes of a filter
            if (b < 2 || fr.ext) begin
              ok = ok & byteMatch(idByteOf(fr.id, b), code[4*f+b], mask[4*f+b]);
            end
          end
          hits[f] = ok;
        end
      end
      caf_pkg::CAF_FILTER_16: begin
        for (int f = 0; f < 4; f++) begin
          hits[f] = byteMatch(idByteOf(fr.id, 0), code[2*f], mask[2*f]) &
                    byteMatch(idByteOf(fr.id, 1), code[2*f+1], mask[2*f+1]);
        end
      end
      caf_pkg::CAF_FILTER_8: begin
        for (int f = 0; f < 8; f++) begin
          hits[f] = byteMatch(idByteOf(fr.id, 0), code[f], mask[f]);
        end
      end
      caf_pkg::CAF_FILTER_SHUT: begin
        hits = 8'h00;
      end
    endcase
    return hits;
  endfunction

  // lowest numbered set bit
  function automatic logic [2:0] firstHit(input logic [7:0] hits);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (hits[i]) begin
        n = 3'(i);
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic       initMode;    // initialization mode acknowledged
  logic       sleepMode;   // sleep mode acknowledged
  logic       counterOk;   // error counters valid to read
  logic       busReq;      // new bus request this cycle
  logic       busWrite;    // write taking effect this cycle
  logic [5:0] wordIdx;     // register word index
  caf_slot_s  slotDec;     // decoded code or mask slot
  logic [7:0] hitVec;      // filter hits for background frame
  logic [2:0] hitFirst;    // lowest hit

  assign initMode  = stateReg.initReq & initAcknowledge;
  assign sleepMode = stateReg.sleepReq & sleepAcknowledge;
  assign counterOk = initMode | sleepMode;
  assign busReq    = cyc_i & stb_i & ~stateReg.ack;
  assign busWrite  = busReq & we_i & sel_i[0];
  assign wordIdx   = adr_i[7:2];
  assign slotDec   = decodeSlot(wordIdx);
  assign hitVec    = filterHits(stateReg.filterMode, stateReg.code, stateReg.mask,
                                stateReg.bgFrame);
  assign hitFirst  = firstHit(hitVec);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // bus slave, frame capture, filtering and foreground load
  always_comb begin
    stateNext             = stateReg;
    stateNext.acceptPulse = 1'b0;
    // bus answers one cycle after the request, then drops
    stateNext.ack         = busReq;

    // read path
    if (busReq) begin
      stateNext.rdData = 32'h0000_0000;  // unmapped reads give zero
      if (slotDec.hit) begin
        // code and mask bytes are readable at any time
        stateNext.rdData[7:0] = slotDec.isMask ? stateReg.mask[slotDec.slot]
                                               : stateReg.code[slotDec.slot];
      end else begin
        unique case (wordIdx)
          caf_pkg::IDX_FILTER_CTRL: begin
            stateNext.rdData[caf_pkg::FILTER_MODE_LSB +: 2] = stateReg.filterMode;
            stateNext.rdData[caf_pkg::FILTER_HIT_LSB +: 3]  = stateReg.hitIndex;
          end
          caf_pkg::IDX_RX_ERR_COUNT: begin
            // zero outside sleep or init mode
            stateNext.rdData[7:0] = counterOk ? rxErrorCount : 8'h00;
          end
          caf_pkg::IDX_TX_ERR_COUNT: begin
            stateNext.rdData[7:0] = counterOk ? txErrorCount : 8'h00;
          end
          caf_pkg::IDX_MODE_CTRL: begin
            stateNext.rdData[caf_pkg::MODE_INIT_BIT]  = stateReg.initReq;
            stateNext.rdData[caf_pkg::MODE_SLEEP_BIT] = stateReg.sleepReq;
          end
          caf_pkg::IDX_RX_STATUS: begin
            stateNext.rdData[caf_pkg::STAT_FULL_BIT]     = stateReg.rxFull;
            stateNext.rdData[caf_pkg::STAT_INIT_ACK_BIT] = initAcknowledge;
            stateNext.rdData[caf_pkg::STAT_SLP_ACK_BIT]  = sleepAcknowledge;
            stateNext.rdData[caf_pkg::STAT_FG_EXT_BIT]   = stateReg.fgFrame.ext;
          end
          caf_pkg::IDX_FG_ID: begin
            stateNext.rdData = stateReg.fgFrame.id;
          end
          default: begin
            stateNext.rdData = 32'h0000_0000;
          end
        endcase
      end
    end

    // write path; counter registers take no writes
    if (busWrite) begin
      if (slotDec.hit) begin
        // filter setup only changes in initialization mode
        if (initMode) begin
          if (slotDec.isMask) begin
            stateNext.mask[slotDec.slot] = dat_i[7:0];
          end else begin
            stateNext.code[slotDec.slot] = dat_i[7:0];
          end
        end
      end else if (wordIdx == caf_pkg::IDX_FILTER_CTRL) begin
        // hit index is read only
        if (initMode) begin
          stateNext.filterMode = dat_i[caf_pkg::FILTER_MODE_LSB +: 2];
        end
      end else if (wordIdx == caf_pkg::IDX_MODE_CTRL) begin
        stateNext.initReq  = dat_i[caf_pkg::MODE_INIT_BIT];
        stateNext.sleepReq = dat_i[caf_pkg::MODE_SLEEP_BIT];
      end else if (wordIdx == caf_pkg::IDX_RX_STATUS) begin
        // write one clears the full flag
        if (dat_i[caf_pkg::STAT_FULL_BIT]) begin
          stateNext.rxFull = 1'b0;
        end
      end
    end

    // filter the background frame one cycle after capture
    stateNext.evalPending = 1'b0;
    if (stateReg.evalPending) begin
      // rejected or queue-busy frames are left for the next frame to overwrite
      if ((|hitVec) && !stateReg.rxFull) begin
        stateNext.fgFrame     = stateReg.bgFrame;
        stateNext.hitIndex    = hitFirst;
        stateNext.rxFull      = 1'b1;
        stateNext.acceptPulse = 1'b1;
      end
    end

    // every incoming frame is written to the background buffer
    if (frameValid) begin
      stateNext.bgFrame     = frameIn;
      stateNext.evalPending = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // single register stage for all state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg             <= '0;
      stateReg.code        <= {8{caf_pkg::RESET_CODE}};
      stateReg.mask        <= {8{caf_pkg::RESET_MASK}};
      stateReg.filterMode  <= caf_pkg::RESET_FILTER_MODE;
      stateReg.initReq     <= caf_pkg::RESET_INIT_REQ;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------
  assign dat_o          = stateReg.rdData;
  assign ack_o          = stateReg.ack;
  assign initRequest    = stateReg.initReq;
  assign sleepRequest   = stateReg.sleepReq;
  assign rxBufferFull   = stateReg.rxFull;
  assign frameAccepted  = stateReg.acceptPulse;
  assign fgFrame        = stateReg.fgFrame;
  assign filterHitIndex = stateReg.hitIndex;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // bus answer is a single-cycle pulse
  chk_ack_single_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held more than one cycle");
  // every new request is answered at the next edge
  chk_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered in one cycle");
  // rx counter read returns live value only in sleep or init
  chk_rxerr_read: assert property (
    busReq && !we_i && wordIdx == caf_pkg::IDX_RX_ERR_COUNT
    |=> dat_o == {24'h00_0000, ($past(counterOk) ? $past(rxErrorCount) : 8'h00)})
    else $error("rx error counter read wrong");
  // tx counter read returns live value only in sleep or init
  chk_txerr_read: assert property (
    busReq && !we_i && wordIdx == caf_pkg::IDX_TX_ERR_COUNT
    |=> dat_o == {24'h00_0000, ($past(counterOk) ? $past(txErrorCount) : 8'h00)})
    else $error("tx error counter read wrong");
  // filter setup unchanged by writes outside init mode
  chk_setup_locked: assert property (
    busWrite && !initMode && slotDec.hit |=> $stable(stateReg.code) && $stable(stateReg.mask))
    else $error("filter setup written outside init mode");
  // each frame is held in the background buffer next cycle
  chk_bg_capture: assert property (
    frameValid |=> stateReg.bgFrame == $past(frameIn) && stateReg.evalPending)
    else $error("frame not captured in background buffer");
  // closed filter never accepts
  chk_closed_drop: assert property (
    stateReg.filterMode == 2'h3 && stateReg.evalPending |=> !frameAccepted)
    else $error("frame accepted with filter closed");
  // accepted frame loads foreground, hit index and full flag together
  chk_accept_load: assert property (
    stateReg.evalPending && (|hitVec) && !rxBufferFull
    |=> frameAccepted && rxBufferFull && filterHitIndex == $past(hitFirst)
        && fgFrame == $past(stateReg.bgFrame))
    else $error("accepted frame not loaded");
  // rejected frame raises nothing
  chk_reject_silent: assert property (
    stateReg.evalPending && !(|hitVec) |=> !frameAccepted)
    else $error("rejected frame signalled");
  // a set in the clearing cycle keeps the flag
  chk_full_set_wins: assert property (
    stateReg.evalPending && (|hitVec) && !rxBufferFull && busWrite
    && wordIdx == caf_pkg::IDX_RX_STATUS |=> rxBufferFull)
    else $error("full flag lost to clear");
  // hit index moves only together with a foreground load
  chk_hit_hold: assert property (!frameAccepted |-> $stable(filterHitIndex))
    else $error("hit index changed without a load");

  cov_accept_32: cover property (frameAccepted && stateReg.filterMode == 2'h0);
  cov_accept_16: cover property (frameAccepted && stateReg.filterMode == 2'h1);
  cov_accept_8: cover property (frameAccepted && stateReg.filterMode == 2'h2 &&
                                filterHitIndex == 3'h7);
  cov_counter_read: cover property (busReq && !we_i && counterOk &&
                                    wordIdx == caf_pkg::IDX_RX_ERR_COUNT);

endmodule

`default_nettype wire
